// ===== design/vst_regs.vh
// Register map, field positions and timing constants of the sync generator
`ifndef VST_REGS_VH
`define VST_REGS_VH

// Register addresses
`define VST_ADDR_GCR 8'h01
`define VST_ADDR_SLV_A 8'h0a
`define VST_ADDR_SLV_B 8'h0b
`define VST_ADDR_OFF_H 8'h0c
`define VST_ADDR_OFF_L 8'h0d
`define VST_ADDR_DIR 8'h0e
`define VST_ADDR_STAT 8'h0f
`define VST_ADDR_GEN 8'hff

// Reset values
`define VST_GCR_RST 8'h00
`define VST_SLV_A_RST 8'h00
`define VST_SLV_B_RST 8'h00
`define VST_OFF_H_RST 2'h0
`define VST_OFF_L_RST 8'h7e
`define VST_DIR_RST 8'hff
`define VST_GEN_RST 8'h00

// Field positions
`define VST_GCR_VFS_HI 1
`define VST_GCR_VFS_LO 0
`define VST_GCR_SLHV 2
`define VST_VFS_PAL 2'h1
`define VST_GEN_TIMING_SOURCE_SELECT 0
`define VST_SLV_VBIT_IGN 0
`define VST_SLV_FSWAP 1
`define VST_SLV_PH_HI 3
`define VST_SLV_PH_LO 2
`define VST_SLV_SQWAVE 4
`define VST_SLV_SAMPLE_ALIGNMENT_COUNT_HI 7
`define VST_SLV_SAMPLE_ALIGNMENT_COUNT_LO 6
`define VST_TRS_F 6
`define VST_TRS_V 5
`define VST_TRS_H 4
`define VST_TRS_PRE1 8'hff
`define VST_TRS_PRE0 8'h00

// Byte phases of the Cb Y Cr Y sequence
`define VST_PH_CB 2'h0
`define VST_PH_Y0 2'h1
`define VST_PH_CR 2'h2
`define VST_PH_Y1 2'h3

// Raster constants, in 13.5 MHz samples and lines
`define VST_LEN_N 10'h35a
`define VST_LEN_P 10'h360
`define VST_LINES_N 10'h20d
`define VST_LINES_P 10'h271
`define VST_ACT_N 10'h078
`define VST_ACT_P 10'h083
`define VST_BASE_N 10'h07e
`define VST_BASE_P 10'h089
`define VST_HALF_N 10'h1ad
`define VST_HALF_P 10'h1b0
`define VST_ACT_LEN 10'h2d0
`define VST_HS_LEN 10'h040
`define VST_BG_DLY 10'h048
`define VST_BG_LEN 10'h022
`define VST_LINE_RST 10'h040
`define VST_F1_START 10'h001
`define VST_F2_N 10'h108
`define VST_F2_P 10'h139
`define VST_VS1_N 10'h004
`define VST_VS2_N 10'h10a
`define VST_VS1_P 10'h001
`define VST_VS2_P 10'h139
`define VST_VS_LINES 10'h003
`define VST_BLK_A_N 10'h009
`define VST_BLK_B0_N 10'h108
`define VST_BLK_B1_N 10'h110
`define VST_BLK_HALF_N 10'h107
`define VST_BLK_A_P 10'h005
`define VST_BLK_B0_P 10'h137
`define VST_BLK_B1_P 10'h13e
`define VST_BLK_C_P 10'h270
`define VST_BLK_HALF_P 10'h26f

`endif

// ===== design/vst_sync2.v
// Two flip-flop synchroniser for asynchronous pin levels
`default_nettype none

module vst_sync2 #(
  parameter W = 2
) (
  input wire clk_i,
  input wire reset_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage is read only by the second stage; reset to the idle high
  // level of the sync pins so no false edge follows reset
  always @(posedge clk_i) begin
    if (reset_i) begin
      meta_r <= {W{1'b1}};
      sync_r <= {W{1'b1}};
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule
`default_nettype wire

// ===== design/vst_trs_detect.v
// Detector for embedded timing reference codes in the byte stream
`include "vst_regs.vh"
`default_nettype none

module vst_trs_detect (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] byte_i,
  output wire trs_o,
  output wire f_o,
  output wire v_o,
  output wire h_o
);

  reg [7:0] b1_r;
  reg [7:0] b2_r;
  reg [7:0] b3_r;
  reg trs_r;
  reg f_r;
  reg v_r;
  reg h_r;
  wire match;

  // Preamble ff 00 00 precedes the code word
  assign match = (b3_r == `VST_TRS_PRE1) && (b2_r == `VST_TRS_PRE0) &&
                 (b1_r == `VST_TRS_PRE0);

  // Flags hold until the next code word; the pulse marks the byte after it
  always @(posedge clk_i) begin
    if (reset_i) begin
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      b3_r <= 8'h00;
      trs_r <= 1'b0;
      f_r <= 1'b0;
      v_r <= 1'b1;
      h_r <= 1'b1;
    end else begin
      b1_r <= byte_i;
      b2_r <= b1_r;
      b3_r <= b2_r;
      trs_r <= match;
      if (match) begin
        f_r <= byte_i[`VST_TRS_F];
        v_r <= byte_i[`VST_TRS_V];
        h_r <= byte_i[`VST_TRS_H];
      end
    end
  end

  assign trs_o = trs_r;
  assign f_o = f_r;
  assign v_o = v_r;
  assign h_o = h_r;

endmodule
`default_nettype wire

// ===== design/vst_timing_gen.v
// Video sync timing generator: registers, counters, sync and blanking
`include "vst_regs.vh"
`default_nettype none

module vst_timing_gen (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] pixel_input_bus_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  input wire [4:0] general_port_i,
  output wire [4:0] general_port_o,
  output wire [4:0] general_port_oe_o,
  output wire [7:0] cb_o,
  output wire [7:0] y_o,
  output wire [7:0] cr_o,
  output wire blank_o,
  output wire burst_gate_o,
  output wire comp_sync_n_o,
  output wire [2:0] field_count_o
);

  reg [7:0] global_control_reg_r;
  reg [7:0] hv_slave_ctrl_a_r;
  reg [7:0] hv_slave_ctrl_b_r;
  reg [1:0] sync_offset_high_r;
  reg [7:0] sync_offset_low_r;
  reg [7:0] port_direction_reg_r;
  reg [7:0] genlock_control_reg_r;
  reg [7:0] rdata_r;
  reg [7:0] pix_r;
  reg [1:0] ph_r;
  reg [9:0] h_r;
  reg [9:0] v_r;
  reg [2:0] fc_r;
  reg fld_r;
  reg [1:0] hv_prev_r;
  reg [7:0] cb_r;
  reg [7:0] y_r;
  reg [7:0] cr_r;
  reg blank_r;
  reg burst_r;
  reg csync_n_r;
  reg [4:0] gp_out_r;
  reg [4:0] gp_oe_r;
  reg [1:0] ph_cur;
  reg [9:0] h_nxt;
  reg [9:0] v_nxt;
  reg [2:0] fc_nxt;
  reg fld_nxt;
  reg new_fld;
  reg fld_in;
  reg load_fld;
  reg [4:0] gp_oe_nxt;
  wire [1:0] hv_sync;
  wire trs_go;
  wire trs_f;
  wire trs_v;
  wire trs_h;

  //////////////////////////////////////////////////////////////////////////
  // Register file

  // Writes land on the addressed register; unknown addresses are ignored
  always @(posedge clk_i) begin
    if (reset_i) begin
      global_control_reg_r <= `VST_GCR_RST;
      hv_slave_ctrl_a_r <= `VST_SLV_A_RST;
      hv_slave_ctrl_b_r <= `VST_SLV_B_RST;
      sync_offset_high_r <= `VST_OFF_H_RST;
      sync_offset_low_r <= `VST_OFF_L_RST;
      port_direction_reg_r <= `VST_DIR_RST;
      genlock_control_reg_r <= `VST_GEN_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `VST_ADDR_GCR) begin
        global_control_reg_r <= reg_wdata_i;
      end else if (reg_addr_i == `VST_ADDR_SLV_A) begin
        hv_slave_ctrl_a_r <= reg_wdata_i;
      end else if (reg_addr_i == `VST_ADDR_SLV_B) begin
        hv_slave_ctrl_b_r <= reg_wdata_i;
      end else if (reg_addr_i == `VST_ADDR_OFF_H) begin
        sync_offset_high_r <= reg_wdata_i[1:0];
      end else if (reg_addr_i == `VST_ADDR_OFF_L) begin
        sync_offset_low_r <= reg_wdata_i;
      end else if (reg_addr_i == `VST_ADDR_DIR) begin
        port_direction_reg_r <= reg_wdata_i;
      end else if (reg_addr_i == `VST_ADDR_GEN) begin
        genlock_control_reg_r <= reg_wdata_i;
      end
    end
  end

  // Mode and field decode
  wire std_pal = global_control_reg_r[`VST_GCR_VFS_HI:`VST_GCR_VFS_LO] ==
                 `VST_VFS_PAL;
  wire slave_hv_select = global_control_reg_r[`VST_GCR_SLHV];
  wire timing_source_select = genlock_control_reg_r[`VST_GEN_TIMING_SOURCE_SELECT];
  wire vbit_ignore = hv_slave_ctrl_a_r[`VST_SLV_VBIT_IGN];
  wire field_swap = hv_slave_ctrl_a_r[`VST_SLV_FSWAP];
  wire sq_wave = hv_slave_ctrl_a_r[`VST_SLV_SQWAVE];
  wire [1:0] chroma_phase_select =
    hv_slave_ctrl_a_r[`VST_SLV_PH_HI:`VST_SLV_PH_LO];
  wire [9:0] sample_alignment_count =
    {hv_slave_ctrl_a_r[`VST_SLV_SAMPLE_ALIGNMENT_COUNT_HI:`VST_SLV_SAMPLE_ALIGNMENT_COUNT_LO], hv_slave_ctrl_b_r};
  wire [9:0] sync_offset_value = {sync_offset_high_r, sync_offset_low_r};
  wire trs_mode = !timing_source_select && !slave_hv_select;

  // Status shows the live raster state
  wire [7:0] status = {1'b0, fc_r, fld_r, blank_r, slave_hv_select,
                       timing_source_select};

  // Read data is registered; unmapped addresses read zero
  always @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= 8'h00;
    end else if (reg_addr_i == `VST_ADDR_GCR) begin
      rdata_r <= global_control_reg_r;
    end else if (reg_addr_i == `VST_ADDR_SLV_A) begin
      rdata_r <= hv_slave_ctrl_a_r;
    end else if (reg_addr_i == `VST_ADDR_SLV_B) begin
      rdata_r <= hv_slave_ctrl_b_r;
    end else if (reg_addr_i == `VST_ADDR_OFF_H) begin
      rdata_r <= {{6{1'b0}}, sync_offset_high_r};
    end else if (reg_addr_i == `VST_ADDR_OFF_L) begin
      rdata_r <= sync_offset_low_r;
    end else if (reg_addr_i == `VST_ADDR_DIR) begin
      rdata_r <= port_direction_reg_r;
    end else if (reg_addr_i == `VST_ADDR_STAT) begin
      rdata_r <= status;
    end else if (reg_addr_i == `VST_ADDR_GEN) begin
      rdata_r <= genlock_control_reg_r;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Standard-dependent raster figures

  // line length, line count and field layout per standard
  wire [9:0] line_len = std_pal ? `VST_LEN_P : `VST_LEN_N;
  wire [9:0] line_cnt = std_pal ? `VST_LINES_P : `VST_LINES_N;
  wire [9:0] act_start = std_pal ? `VST_ACT_P : `VST_ACT_N;
  wire [9:0] off_base = std_pal ? `VST_BASE_P : `VST_BASE_N;
  wire [9:0] half_line = std_pal ? `VST_HALF_P : `VST_HALF_N;
  wire [9:0] f2_start = std_pal ? `VST_F2_P : `VST_F2_N;
  wire [9:0] vs1 = std_pal ? `VST_VS1_P : `VST_VS1_N;
  wire [9:0] vs2 = std_pal ? `VST_VS2_P : `VST_VS2_N;

  // hs position follows the offset, wrapped modulo the line length
  wire [11:0] len12 = {2'b00, line_len};
  wire [11:0] hs_raw = {2'b00, sync_offset_value} + {2'b00, act_start} +
                       len12 - {2'b00, off_base};
  wire [11:0] hs_wrap = (hs_raw >= (len12 << 1)) ? hs_raw - (len12 << 1) :
                        (hs_raw >= len12) ? hs_raw - len12 : hs_raw;
  // reset offset lands hs exactly on the first chroma sample in NTSC; in PAL it lands 11 samples earlier
  wire [9:0] hs_pos = hs_wrap[9:0];

  //////////////////////////////////////////////////////////////////////////
  // Inputs: sync pins and embedded codes

  // Pin levels cross into the clock domain before use
  vst_sync2 #(.W(2)) u_hv_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(general_port_i[1:0]),
    .sync_o(hv_sync)
  );

  // reference codes are decoded from the captured bytes
  vst_trs_detect u_trs (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .byte_i(pix_r),
    .trs_o(trs_go),
    .f_o(trs_f),
    .v_o(trs_v),
    .h_o(trs_h)
  );

  wire trs_sav = trs_mode && trs_go && !trs_h;
  wire hs_fall = hv_prev_r[1] && !hv_sync[1];
  wire vs_fall = hv_prev_r[0] && !hv_sync[0];
  wire vs_edge = hv_prev_r[0] != hv_sync[0];

  //////////////////////////////////////////////////////////////////////////
  // Counters

  // Next state of phase, horizontal and vertical counters and field count
  always @* begin
    ph_cur = trs_sav ? `VST_PH_CB : ph_r;
    h_nxt = h_r;
    v_nxt = v_r;
    fc_nxt = fc_r;
    fld_nxt = fld_r;
    new_fld = 1'b0;
    fld_in = fld_r;
    load_fld = 1'b0;
    // one count per two pixel bytes
    if (ph_cur[0]) begin
      if (h_r >= line_len - 10'h001) begin
        h_nxt = 10'h000;
        if (v_r >= line_cnt) begin
          v_nxt = `VST_F1_START;
        end else begin
          v_nxt = v_r + 10'h001;
        end
        new_fld = (v_nxt == `VST_F1_START) || (v_nxt == f2_start);
        fld_in = (v_nxt == f2_start);
      end else begin
        h_nxt = h_r + 10'h001;
      end
    end
    if (slave_hv_select) begin
      // hs falling edge aligns the horizontal counter
      if (hs_fall) begin
        h_nxt = sample_alignment_count;
      end
      // square wave: either edge, level gives the field
      if (sq_wave ? vs_edge : vs_fall) begin
        load_fld = 1'b1;
        fld_in = sq_wave ? !hv_sync[0] : !fld_r;
      end
    end else if (trs_mode && trs_go) begin
      // start of active video fixes the horizontal position
      if (!trs_h) begin
        h_nxt = act_start;
      end
      if (trs_f != fld_r) begin
        load_fld = 1'b1;
        fld_in = trs_f;
      end
    end
    if (load_fld) begin
      new_fld = 1'b1;
      fld_in = fld_in ^ (field_swap && !(trs_mode && !trs_go));
      v_nxt = fld_in ? f2_start : `VST_F1_START;
    end
    if (new_fld) begin
      fld_nxt = fld_in;
      // four-field count in NTSC, eight in PAL
      fc_nxt = fc_r + 3'h1;
      if (!std_pal) begin
        fc_nxt[2] = 1'b0;
      end
    end
  end

  // reset restarts at line 64 at the start of hs
  always @(posedge clk_i) begin
    if (reset_i) begin
      ph_r <= `VST_PH_CB;
      h_r <= `VST_ACT_N;
      v_r <= `VST_LINE_RST;
      fc_r <= 3'h0;
      fld_r <= 1'b0;
      hv_prev_r <= 2'h3;
    end else begin
      ph_r <= ph_cur + 2'h1;
      h_r <= h_nxt;
      v_r <= v_nxt;
      fc_r <= fc_nxt;
      fld_r <= fld_nxt;
      hv_prev_r <= hv_sync;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pixel capture and chroma alignment

  // the phase select rotates which byte is taken as Cb, Y or Cr
  wire [1:0] sel = ph_cur + chroma_phase_select;

  // bytes are taken on the rising edge; wrong phase swaps colours
  always @(posedge clk_i) begin
    if (reset_i) begin
      pix_r <= 8'h00;
      cb_r <= 8'h00;
      y_r <= 8'h00;
      cr_r <= 8'h00;
    end else begin
      pix_r <= pixel_input_bus_i;
      case (sel)
        `VST_PH_CB: cb_r <= pix_r;
        `VST_PH_CR: cr_r <= pix_r;
        default: y_r <= pix_r;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sync, blanking and port drive

  // 64 samples long; cut short when it would pass the line end
  wire hs_act = (h_r >= hs_pos) && (h_r < hs_pos + `VST_HS_LEN);
  wire bg_act = (h_r >= hs_pos + `VST_BG_DLY) &&
                (h_r < hs_pos + `VST_BG_DLY + `VST_BG_LEN);
  // vs marks the field datum, field two half a line later
  wire vs_act = (v_r >= vs1 && v_r < vs1 + `VST_VS_LINES) ||
                (v_r == vs2 && h_r >= half_line) ||
                (v_r > vs2 && v_r < vs2 + `VST_VS_LINES) ||
                (v_r == vs2 + `VST_VS_LINES && h_r < half_line);
  wire h_blank = (h_r < act_start) || (h_r >= act_start + `VST_ACT_LEN);
  wire vb_ntsc = (v_r <= `VST_BLK_A_N) ||
                 (v_r >= `VST_BLK_B0_N && v_r <= `VST_BLK_B1_N) ||
                 (v_r == `VST_BLK_HALF_N && h_r >= half_line);
  wire vb_pal = (v_r <= `VST_BLK_A_P) ||
                (v_r >= `VST_BLK_B0_P && v_r <= `VST_BLK_B1_P) ||
                (v_r >= `VST_BLK_C_P) ||
                (v_r == `VST_BLK_HALF_P && h_r >= half_line);
  // the V bit blanks unless ignored
  wire trs_blank = trs_h || (trs_v && !vbit_ignore);
  // code mode follows the H and V bits, other modes the standard raster
  wire blank_nxt = trs_mode ? trs_blank :
                   (h_blank || (std_pal ? vb_pal : vb_ntsc));

  // Pin direction: low bit in the direction register means output
  always @* begin
    gp_oe_nxt = ~port_direction_reg_r[4:0];
    // master mode forces bits 0-4 to drive
    if (timing_source_select) begin
      gp_oe_nxt = 5'h1f;
    end
    // slave H&V forces the sync pins to inputs, overriding master
    if (slave_hv_select) begin
      gp_oe_nxt[1:0] = 2'h0;
    end
  end

  // Outputs are registered so they do not glitch at pins
  always @(posedge clk_i) begin
    if (reset_i) begin
      blank_r <= 1'b1;
      burst_r <= 1'b0;
      csync_n_r <= 1'b1;
      gp_out_r <= 5'h00;
      gp_oe_r <= 5'h00;
    end else begin
      blank_r <= blank_nxt;
      // Burst follows hs by 72 samples; only vertical blanking removes it
      burst_r <= bg_act && !(trs_mode ? (trs_v && !vbit_ignore) :
                                        (std_pal ? vb_pal : vb_ntsc));
      csync_n_r <= !(hs_act || vs_act);
      // active-low vs and hs with the field count above them
      gp_out_r <= timing_source_select ? {fc_r, !hs_act, !vs_act} : 5'h00;
      gp_oe_r <= gp_oe_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign general_port_o = gp_out_r;
  assign general_port_oe_o = gp_oe_r;
  assign cb_o = cb_r;
  assign y_o = y_r;
  assign cr_o = cr_r;
  assign blank_o = blank_r;
  assign burst_gate_o = burst_r;
  assign comp_sync_n_o = csync_n_r;
  assign field_count_o = fc_r;

endmodule
`default_nettype wire

// ===== test/vst_upstream_model.sv
// Behavioural upstream decoder: byte stream with embedded timing codes
`default_nettype none

module vst_upstream_model (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [7:0] xy_i,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] step_r = 3'h0;
  logic [1:0] ph_r = 2'h0;
  logic [7:0] xy_r = 8'h00;

  initial byte_o = 8'h11;

  ////////////////////////////////////////////////////////////////////////////
  // Request is taken at the edge; bytes move 1 ns later, clear of sampling
  // code then data
  always @(posedge clk_i) begin : drive
    logic go;
    go = send_i;
    #1;
    if (go) begin
      step_r = 3'h1;
      xy_r = xy_i;
    end
    if (step_r != 3'h0) begin
      byte_o = (step_r == 3'h4) ? xy_r : {8{step_r == 3'h1}};
      step_r = (step_r == 3'h4) ? 3'h0 : step_r + 3'h1;
      ph_r = 2'h0;
    end else begin
      // Distinct bytes per phase, never ff or 00, so no false code
      byte_o = 8'h11 * ({6'h00, ph_r} + 8'h01);
      ph_r = ph_r + 2'h1;
    end
  end
endmodule

`default_nettype wire

// ===== test/vst_timing_props.sv
// Port-level checker of the sync timing generator
`default_nettype none

module vst_timing_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [4:0] general_port_o,
  input wire logic [4:0] general_port_oe_o,
  input wire logic blank_o,
  input wire logic [2:0] field_count_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  logic gen_r;
  logic slhv_r;
  logic [1:0] st_r;
  logic [7:0] lo_r;
  wire mode_wr = reg_wr_i && (reg_addr_i == 8'hff || reg_addr_i == 8'h01);
  wire settled = (st_r == 2'h3);

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the mode bits; settle count covers register plus pin stage
  always @(posedge clk_i) begin
    if (reset_i) begin
      gen_r <= 1'b0;
      slhv_r <= 1'b0;
      st_r <= 2'h0;
    end else if (mode_wr) begin
      st_r <= 2'h0;
      if (reg_addr_i == 8'hff)
        gen_r <= reg_wdata_i[0];
      else
        slhv_r <= reg_wdata_i[2];
    end else if (!settled) begin
      st_r <= st_r + 2'h1;
    end
  end

  // Length of the current low stretch of the driven sync pin
  always @(posedge clk_i) begin
    if (reset_i || !(general_port_oe_o[1] && !general_port_o[1]))
      lo_r <= 8'h00;
    else if (lo_r != 8'hff)
      lo_r <= lo_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_reset;
    disable iff (1'b0) reset_i |=> blank_o && general_port_o == 5'h00 &&
      general_port_oe_o == 5'h00 && field_count_o == 3'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs wrong after reset");

  property p_master_oe;
    settled && gen_r && !slhv_r |-> general_port_oe_o == 5'h1f;
  endproperty
  a_master_oe: assert property (p_master_oe)
    else $error("master mode does not drive port bits");

  property p_slave_in;
    settled && slhv_r |-> general_port_oe_o[1:0] == 2'h0;
  endproperty
  a_slave_in: assert property (p_slave_in)
    else $error("sync pins driven in slave mode");

  property p_idle_port;
    settled && !gen_r && !slhv_r |-> general_port_o == 5'h00;
  endproperty
  a_idle_port: assert property (p_idle_port)
    else $error("port driven outside master mode");

  property p_hs_len;
    lo_r <= 8'h80;
  endproperty
  a_hs_len: assert property (p_hs_len)
    else $error("sync pulse longer than 64 samples");

  property p_wr_rd;
    reg_wr_i && reg_addr_i == 8'h0d ##1 !reg_wr_i && reg_addr_i == 8'h0d
      |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("offset low read back differs");

  property p_unmapped;
    !(reg_addr_i inside {8'h01, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
      8'hff}) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address reads nonzero");

  property p_field_pins;
    general_port_oe_o[4] && $stable(field_count_o) &&
      $stable(general_port_o[4:2]) |-> general_port_o[4:2] == field_count_o;
  endproperty
  a_field_pins: assert property (p_field_pins)
    else $error("field pins differ from field count");

  c_hs: cover property (general_port_oe_o[1] && $fell(general_port_o[1]));
  c_slave: cover property (settled && slhv_r);
  c_blank: cover property ($fell(blank_o));
endmodule

bind vst_timing_gen vst_timing_props u_props (
  .clk_i(clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .general_port_o(general_port_o),
  .general_port_oe_o(general_port_oe_o), .blank_o(blank_o),
  .field_count_o(field_count_o)
);

`default_nettype wire

// ===== test/test_video_sync_timing_generator.sv
// Self-checking bench of the sync timing generator
`default_nettype none

module test_video_sync_timing_generator;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic send = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] xy = 8'h00;
  logic [7:0] v;
  logic [4:0] drv = 5'h03;
  logic [7:0] b[4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  logic [7:0] ra[8] = '{8'h01, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'hff,
    8'h55};
  logic [7:0] re[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7e, 8'hff, 8'h00,
    8'h00};
  wire [7:0] pix, reg_rdata_o, cb_o, y_o, cr_o;
  wire [4:0] gp_o, gp_oe, gp_in;
  wire [2:0] fc;
  wire blank_o, burst, csync_n;
  int errors = 0;
  int n_compared = 0;
  int n;

  always #20 clk_i = ~clk_i;

  // Pin level: design drive where enabled, bench levels elsewhere
  assign gp_in = (gp_oe & gp_o) | (~gp_oe & drv);

  vst_upstream_model u_src (.clk_i(clk_i), .send_i(send), .xy_i(xy),
    .byte_o(pix));

  vst_timing_gen dut (.clk_i(clk_i), .reset_i(reset_i),
    .pixel_input_bus_i(pix), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .general_port_i(gp_in), .general_port_o(gp_o),
    .general_port_oe_o(gp_oe), .cb_o(cb_o), .y_o(y_o), .cr_o(cr_o),
    .blank_o(blank_o), .burst_gate_o(burst), .comp_sync_n_o(csync_n),
    .field_count_o(fc));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
  endtask

  // Read data is registered one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    reg_addr_i = a;
    tick(2);
    d = reg_rdata_o;
  endtask

  // One embedded code, then time for the stream to reach the outputs
  task automatic code(input logic [7:0] c);
    tick(1);
    xy = c;
    send = 1'b1;
    tick(1);
    send = 1'b0;
    tick(16);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under 20000 cycles
  initial begin
    #(40 * 60000);
    errors++;
    wrap_up();
  end

  initial begin
    tick(20);
    reset_i = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], v);
      chk(v, re[i]);
    end
    wr(8'h0d, 8'ha5);
    rd(8'h0d, v);
    chk(v, 8'ha5);
    wr(8'h0c, 8'h03);
    rd(8'h0c, v);
    chk(v, 8'h03);
    wr(8'h0d, 8'h7e);
    wr(8'h0c, 8'h00);
    $display("test registers done");
    // Every chroma phase choice on the same Cb Y Cr Y stream
    for (int i = 0; i < 4; i++) begin
      wr(8'h0a, 8'(i << 2));
      code(8'h80);
      chk(cb_o, b[(4 - i) % 4]);
      chk(cr_o, b[(6 - i) % 4]);
      chk(y_o, b[1 + (i % 2)]);
      chk({7'h00, blank_o}, 8'h00);
    end
    code(8'h90);
    chk({7'h00, blank_o}, 8'h01);
    code(8'ha0);
    chk({7'h00, blank_o}, 8'h01);
    wr(8'h0a, 8'h01);
    code(8'ha0);
    chk({7'h00, blank_o}, 8'h00);
    $display("test embedded codes done");
    // Slave first, then timing source, so the pins never clash
    wr(8'h01, 8'h04);
    wr(8'h0f, 8'h55);
    wr(8'hff, 8'h01);
    // NTSC sample 119 sits one before hs at 120 and counts into it; PAL sample 227 lies outside it
    for (int f = 0; f < 2; f++) begin
      wr(8'h01, 8'(8'h04 | f));
      wr(8'h0b, f ? 8'he3 : 8'h77);
      wr(8'h0a, 8'(8'h10 | (f << 1)));
      // Vs edge together with the hs fall
      drv[1:0] = 2'b00;
      tick(6);
      chk({7'h00, gp_o[1]}, 8'(f));
      rd(8'h0f, v);
      chk({7'h00, v[3]}, 8'(1 - f));
      chk({6'h00, v[1], gp_oe[1]}, 8'h02);
      drv[1:0] = 2'b11;
      tick(6);
      rd(8'h0f, v);
      chk({7'h00, v[3]}, 8'(f));
    end
    $display("test slave pins done");
    wr(8'h01, 8'h00);
    tick(4);
    chk({3'h0, gp_oe}, 8'h1f);
    n = 0;
    while (gp_o[1] !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    while (gp_o[1] !== 1'b0 && n < 4000) begin
      tick(1);
      n++;
    end
    chk({7'h00, csync_n}, 8'h00);
    n = 0;
    while (gp_o[1] === 1'b0 && n < 300) begin
      tick(1);
      n++;
    end
    // 64 samples, each two clocks
    chk(8'(n), 8'h80);
    // Line clear of vertical blanking: burst after hs, sync released
    tick(20);
    chk({6'h00, burst, csync_n}, 8'h03);
    $display("test master sync done");
    wr(8'h0d, 8'h55);
    tick(1);
    reset_i = 1'b1;
    tick(2);
    reset_i = 1'b0;
    chk({7'h00, blank_o}, 8'h01);
    chk({3'h0, gp_oe}, 8'h00);
    rd(8'h0d, v);
    chk(v, 8'h7e);
    $display("test second reset done");
    wrap_up();
  end
endmodule

`default_nettype wire
